// ==== src/brake_pkg.sv ====
// package: constants and types for the holding-brake sequencer
// assumes a 100 MHz ref_clk_in and a plain address/strobe register port
package brake_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned STEP_MS = 10;
	localparam int unsigned STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
	localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);
	// register offsets (word index)
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] DELAY_ADDR = 4'h1;
	localparam logic [3:0] THRESH_ADDR = 4'h2;
	localparam logic [3:0] WAIT_ADDR = 4'h3;
	localparam logic [3:0] ASSIGN_ADDR = 4'h4;
	localparam logic [3:0] STATUS_ADDR = 4'h5;
	// ctrl register fields
	localparam int CTRL_SERVO_ON_BIT = 0;
	// status fields
	localparam int ST_RELEASE_BIT = 0;
	localparam int ST_POWER_BIT = 1;
	localparam int ST_STATE_LSB = 2;
	// reset values and limits
	localparam logic [5:0] DELAY_RESET = 6'h00;
	localparam logic [5:0] DELAY_MAX = 6'h32;
	localparam logic [15:0] THRESH_RESET = 16'h0064;
	localparam logic [6:0] WAIT_RESET = 7'h32;
	localparam logic [6:0] WAIT_MIN = 7'h0a;
	localparam logic [6:0] WAIT_MAX = 7'h64;
	localparam logic [1:0] ASSIGN_RESET = 2'h1;
	typedef enum logic [3:0] {
		ST_OFF = 4'b0001,
		ST_RUN = 4'b0010,
		ST_STOP_DLY = 4'b0100,
		ST_COAST = 4'b1000
	} seq_state_t;
endpackage : brake_pkg

// ==== src/brake_regs_if.sv ====
// interface: register values passed from the register file to the sequencer
// assumes both ends sit on ref_clk_in
`timescale 1ns/1ps
`default_nettype none
interface brake_regs_if;
	logic servo_on;
	logic [5:0] delay_steps;
	logic [15:0] speed_thresh;
	logic [6:0] wait_steps;
	logic [1:0] term_assign;
	modport regs (output servo_on, delay_steps, speed_thresh, wait_steps,
		term_assign);
	modport core (input servo_on, delay_steps, speed_thresh, wait_steps,
		term_assign);
endinterface : brake_regs_if
`default_nettype wire

// ==== src/brake_regs.sv ====
// module: software registers of the brake sequencer
// assumes one-cycle strobes; read data stand the cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module brake_regs
	import brake_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [31:0] status_in,
	output logic [31:0] rdata_out,
	brake_regs_if.regs cfg
);
	logic [1:0] assign_sw;
	logic [31:0] rd_mux;
	logic [5:0] wr_delay;
	logic [6:0] wr_wait;

	// clamp written values into the legal ranges
	assign wr_delay = (wdata_in[5:0] > DELAY_MAX) ? DELAY_MAX : wdata_in[5:0];
	assign wr_wait = (wdata_in[6:0] < WAIT_MIN) ? WAIT_MIN :
		(wdata_in[6:0] > WAIT_MAX) ? WAIT_MAX : wdata_in[6:0];

	// read select; unmapped offsets read zero
	assign rd_mux = (addr_in == CTRL_ADDR) ? {31'h0, cfg.servo_on} :
		(addr_in == DELAY_ADDR) ? {26'h0, cfg.delay_steps} :
		(addr_in == THRESH_ADDR) ? {16'h0, cfg.speed_thresh} :
		(addr_in == WAIT_ADDR) ? {25'h0, cfg.wait_steps} :
		(addr_in == ASSIGN_ADDR) ? {30'h0, assign_sw} :
		(addr_in == STATUS_ADDR) ? status_in : 32'h0;

	// register writes; delay/threshold/wait apply at once
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cfg.servo_on <= 1'b0;
			cfg.delay_steps <= DELAY_RESET;
			cfg.speed_thresh <= THRESH_RESET;
			cfg.wait_steps <= WAIT_RESET;
			assign_sw <= ASSIGN_RESET;
			rdata_out <= 32'h0;
		end
		else
		begin
			rdata_out <= rd_in ? rd_mux : 32'h0;
			if (wr_in && addr_in == CTRL_ADDR)
				cfg.servo_on <= wdata_in[CTRL_SERVO_ON_BIT];
			if (wr_in && addr_in == DELAY_ADDR)
				cfg.delay_steps <= wr_delay;
			if (wr_in && addr_in == THRESH_ADDR)
				cfg.speed_thresh <= wdata_in[15:0];
			if (wr_in && addr_in == WAIT_ADDR)
				cfg.wait_steps <= wr_wait;
			if (wr_in && addr_in == ASSIGN_ADDR)
				assign_sw <= wdata_in[1:0];
		end
	end

	// terminal routing is latched only by reset (restart)
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cfg.term_assign <= ASSIGN_RESET;
		else
			cfg.term_assign <= cfg.term_assign;
	end
endmodule : brake_regs
`default_nettype wire

// ==== src/holding_brake_sequencer.sv ====
// top: holding-brake sequencer of a servo drive
// assumes alarm, motor_stopped and speed arrive asynchronously and are
// resynchronised here; servo on/off comes from software or pins
// How it works
// - alarm or servo-off drops brake release
// - output high releases, low applies brake
// - brake fixed to terminal 1; field read back only
// - terminal output is OR of assigned signals
// - stopped servo-off drops brake same cycle
// - power removal delayed by 10 ms steps
// - delay only when stopped; alarm immediate
// - alarm cuts motor power at once
// - rotating: brake at once; off below speed or timeout
`timescale 1ns/1ps
`default_nettype none
module holding_brake_sequencer
	import brake_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic servo_on_command_in,
	input wire logic servo_off_command_in,
	input wire logic alarm_in,
	input wire logic motor_stopped_in,
	input wire logic [15:0] motor_speed_in,
	input wire logic [2:0] other_terminal_in,
	output logic motor_power_out,
	output logic brake_release_output,
	output logic [2:0] terminal_out
);
	brake_regs_if regs_bus ();
	seq_state_t state, next_state;
	logic [1:0] alarm_sync, stop_sync, on_sync, off_sync;
	logic [15:0] speed_s1, speed_s2;
	logic on_prev, off_prev;
	logic [23:0] tick_cnt;
	logic [6:0] step_cnt;
	logic alarm, stopped, on_edge, off_edge, on_sw_prev, on_sw_edge;
	logic off_sw_edge, servo_on_req, servo_off_req, tick;
	logic slow, timeout, delay_done, next_power, in_run;
	logic [31:0] status;

	// latency: a pin command passes two sync flops and an edge detect,
	// so it acts three edges after the pin moves; a software write to
	// the servo-on bit acts one edge after the write is taken. the host
	// must hold off references for a while after release; nothing here
	// polices that, since no reference enters this block
	// (the alarm is a level, so it needs no edge detect of its own)

	// states that keep the motor energised
	function automatic logic holds_power(input seq_state_t s);
		holds_power = (s == ST_RUN) || (s == ST_STOP_DLY);
	endfunction : holds_power

	////////////////////////////////////////////////////////////////
	brake_regs u_regs (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.status_in(status),
		.rdata_out(rdata_out),
		.cfg(regs_bus.regs)
	);

	////////////////////////////////////////////////////////////////
	// two-flop synchronisers; the speed bus may tear, but only a
	// compare against the threshold reads it, so a glitch costs a cycle
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			alarm_sync <= 2'h0;
			stop_sync <= 2'h0;
			on_sync <= 2'h0;
			off_sync <= 2'h0;
			speed_s1 <= 16'h0;
			speed_s2 <= 16'h0;
		end
		else
		begin
			alarm_sync <= {alarm_sync[0], alarm_in};
			stop_sync <= {stop_sync[0], motor_stopped_in};
			on_sync <= {on_sync[0], servo_on_command_in};
			off_sync <= {off_sync[0], servo_off_command_in};
			speed_s1 <= motor_speed_in;
			speed_s2 <= speed_s1;
		end
	end

	// edge memory of commands
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			on_prev <= 1'b0;
			off_prev <= 1'b0;
			on_sw_prev <= 1'b0;
		end
		else
		begin
			on_prev <= on_sync[1];
			off_prev <= off_sync[1];
			on_sw_prev <= regs_bus.servo_on;
		end
	end

	// command decode: pin pulses or the software servo-on bit
	assign alarm = alarm_sync[1];
	assign stopped = stop_sync[1];
	assign on_edge = on_sync[1] & ~on_prev;
	assign off_edge = off_sync[1] & ~off_prev;
	assign on_sw_edge = regs_bus.servo_on & ~on_sw_prev;
	assign off_sw_edge = ~regs_bus.servo_on & on_sw_prev;
	assign servo_on_req = (on_edge | on_sw_edge) & ~alarm;
	assign servo_off_req = off_edge | off_sw_edge;

	////////////////////////////////////////////////////////////////
	// 10 ms tick, restarted on each state change so steps are whole
	// the trade: a state lasts whole steps plus up to one cycle, and the
	// step count may wrap in run or off, where nobody reads it
	assign tick = (tick_cnt == STEP_LAST);
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			tick_cnt <= 24'h0;
			step_cnt <= 7'h0;
		end
		else if (next_state != state)
		begin
			tick_cnt <= 24'h0;
			step_cnt <= 7'h0;
		end
		else if (tick)
		begin
			tick_cnt <= 24'h0;
			step_cnt <= step_cnt + 7'h1;
		end
		else
			tick_cnt <= tick_cnt + 24'h1;
	end

	// delay is read live so a new value applies at once
	assign delay_done = (step_cnt >= {1'b0, regs_bus.delay_steps});
	assign slow = (speed_s2 < regs_bus.speed_thresh);
	assign timeout = (step_cnt >= regs_bus.wait_steps);

	////////////////////////////////////////////////////////////////
	// sequencing of motor power and brake release
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_OFF:
				if (servo_on_req)
					next_state = ST_RUN;
			ST_RUN:
				if (alarm)
					next_state = stopped ? ST_OFF : ST_COAST;
				else if (servo_off_req)
					next_state = stopped ? ST_STOP_DLY : ST_COAST;
			ST_STOP_DLY:
				if (alarm || delay_done)
					next_state = ST_OFF;
			ST_COAST:
				if (slow || timeout)
					next_state = ST_OFF;
			default:
				next_state = ST_OFF;
		endcase
	end

	// power stays only while running or counting the stopped delay;
	// release needs run state and no alarm or servo-off this cycle
	assign next_power = holds_power(next_state);
	assign in_run = (state == ST_RUN);

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state <= ST_OFF;
			motor_power_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			motor_power_out <= next_power;
		end
	end

	// release drops combinationally with alarm or servo-off so the
	// brake engages in the same cycle the command is seen
	assign brake_release_output = in_run && motor_power_out &&
		!alarm && !servo_off_req;

	////////////////////////////////////////////////////////////////
	// terminal routing, each terminal ORs its other signals
	// limitation: the routing field holds its reset value, so a value
	// written to the assign register is only read back; a restart
	// reloads the default, and pairs 2 and 3 carry their own signals
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_term
			assign terminal_out[gi] = other_terminal_in[gi] |
				(brake_release_output &&
				regs_bus.term_assign == 2'(gi + 1));
		end
	endgenerate

	// status: release, power, state code
	assign status = {26'h0, state, motor_power_out, brake_release_output};
endmodule : holding_brake_sequencer
`default_nettype wire

// ==== sim/brake_relay_model.sv ====
// model: external brake relay wired to the first output terminal pair
// assumes the coil follows the terminal level one clock later
`timescale 1ns/1ps
`default_nettype none
module brake_relay_model (
	input wire logic ref_clk_in,
	input wire logic coil_in,
	output logic brake_applied_out
);
	// coil closed lifts the lining; an open coil lets the spring hold
	always_ff @(posedge ref_clk_in)
	begin
		brake_applied_out <= !coil_in;
	end
endmodule : brake_relay_model
`default_nettype wire

// ==== sim/brake_assertions.sv ====
// checker: port timing of the holding-brake sequencer
// assumes the power-off delay stays 0 while brake events are exercised
`timescale 1ns/1ps
`default_nettype none
module brake_assertions (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic servo_off_command_in,
	input wire logic alarm_in,
	input wire logic [2:0] other_terminal_in,
	input wire logic motor_power_out,
	input wire logic brake_release_output,
	input wire logic [2:0] terminal_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	////////////////////////////////////////////////////////////////////////
	// routing is fixed to pair 1, also after restart; others pass through
	AST_TERM_ROUTE: assert property (terminal_out[0] ==
		(other_terminal_in[0] | brake_release_output))
		else $error("brake terminal not routed");
	AST_TERM_OTHERS: assert property (
		terminal_out[2:1] == other_terminal_in[2:1])
		else $error("other terminals disturbed");
	AST_REL_POWER: assert property (
		brake_release_output |-> motor_power_out)
		else $error("brake released without power");
	AST_ON_TOGETHER: assert property (
		$rose(brake_release_output) |-> $rose(motor_power_out))
		else $error("release and power not together");
	// the alarm passes two sync flops, so three samples are needed
	AST_ALARM_REL: assert property (
		alarm_in [*3] |-> !brake_release_output)
		else $error("brake not applied on alarm");
	AST_ALARM_POWER: assert property (
		alarm_in [*4] |-> !motor_power_out)
		else $error("power kept on alarm");
	AST_OFF_REL: assert property (
		$rose(servo_off_command_in) |-> ##[1:4] !brake_release_output)
		else $error("brake not applied on servo off");
	AST_FALL_POWER: assert property (
		$fell(brake_release_output) |-> ##[0:2] !motor_power_out)
		else $error("power not removed after zero delay");
endmodule : brake_assertions
bind holding_brake_sequencer brake_assertions brake_assertions_inst (
	.ref_clk_in(ref_clk_in),
	.rstn_in(rstn_in),
	.servo_off_command_in(servo_off_command_in),
	.alarm_in(alarm_in),
	.other_terminal_in(other_terminal_in),
	.motor_power_out(motor_power_out),
	.brake_release_output(brake_release_output),
	.terminal_out(terminal_out)
);
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: register and pin sequences for the brake sequencer
// assumes a relay model on terminal pair 1 and a bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import brake_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic servo_on_command_in = 1'b0;
	logic servo_off_command_in = 1'b0;
	logic alarm_in = 1'b0;
	logic motor_stopped_in = 1'b1;
	logic [15:0] motor_speed_in = 16'h0;
	logic [2:0] other_terminal_in = 3'h0;
	logic [31:0] rdata_out;
	logic motor_power_out;
	logic brake_release_output;
	logic brake_applied;
	logic [2:0] terminal_out;
	int n_fail = 0;
	int comparisons = 0;
	holding_brake_sequencer holding_brake_sequencer_inst (
		.ref_clk_in(ref_clk_in),
		.rstn_in(rstn_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.servo_on_command_in(servo_on_command_in),
		.servo_off_command_in(servo_off_command_in),
		.alarm_in(alarm_in),
		.motor_stopped_in(motor_stopped_in),
		.motor_speed_in(motor_speed_in),
		.other_terminal_in(other_terminal_in),
		.motor_power_out(motor_power_out),
		.brake_release_output(brake_release_output),
		.terminal_out(terminal_out)
	);
	brake_relay_model brake_relay_model_inst (.ref_clk_in(ref_clk_in),
		.coil_in(terminal_out[0]), .brake_applied_out(brake_applied));
	initial
	begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// strobes drop after their edge, so back-to-back calls never clash
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		#1 chk("rdata_out", exp, rdata_out);
		@(posedge ref_clk_in);
	endtask : rd
	// ends at a falling edge so the caller samples settled outputs
	task automatic wait_rel(input logic v);
		int i;
		for (i = 0; i < 20; i++)
		begin
			@(negedge ref_clk_in);
			if (brake_release_output === v)
				break;
		end
		if (i == 20)
		begin
			n_fail++;
			$display("CHECK FAILED brake_release_output expected %h seen %h",
				v, brake_release_output);
			report_and_stop();
		end
	endtask : wait_rel
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		@(posedge ref_clk_in);
		rd(DELAY_ADDR, 32'h0);
		rd(THRESH_ADDR, 32'h64);
		rd(WAIT_ADDR, 32'h32);
		rd(ASSIGN_ADDR, 32'h1);
		rd(STATUS_ADDR, 32'h4);
		rd(4'hf, 32'h0);
		wr(DELAY_ADDR, 32'h3f);
		rd(DELAY_ADDR, 32'h32);
		wr(WAIT_ADDR, 32'h5);
		rd(WAIT_ADDR, 32'h0a);
		wr(DELAY_ADDR, 32'h0);
		wr(ASSIGN_ADDR, 32'h3);
		rd(ASSIGN_ADDR, 32'h3);
		// routing keeps pair 1 despite the write, ored with the others
		other_terminal_in <= 3'b110;
		servo_on_command_in <= 1'b1;
		// no reference input exists, so none is sent after release
		wait_rel(1'b1);
		chk("power", 32'h1, 32'(motor_power_out));
		chk("terminal", 32'h7, 32'(terminal_out));
		@(posedge ref_clk_in);
		servo_on_command_in <= 1'b0;
		rd(STATUS_ADDR, 32'h0b);
		@(negedge ref_clk_in);
		chk("brake_applied", 32'h0, 32'(brake_applied));
		@(posedge ref_clk_in);
		// stopped servo-off: brake first, power held through the delay state
		servo_off_command_in <= 1'b1;
		wait_rel(1'b0);
		chk("power", 32'h1, 32'(motor_power_out));
		@(negedge ref_clk_in);
		chk("power", 32'h1, 32'(motor_power_out));
		@(negedge ref_clk_in);
		chk("power", 32'h0, 32'(motor_power_out));
		@(posedge ref_clk_in);
		servo_off_command_in <= 1'b0;
		rd(STATUS_ADDR, 32'h4);
		// alarm while rotating: coast, then off once speed is low
		wr(CTRL_ADDR, 32'h1);
		wait_rel(1'b1);
		@(posedge ref_clk_in);
		motor_stopped_in <= 1'b0;
		motor_speed_in <= 16'h01f4;
		alarm_in <= 1'b1;
		wait_rel(1'b0);
		@(negedge ref_clk_in);
		chk("power", 32'h0, 32'(motor_power_out));
		@(posedge ref_clk_in);
		servo_on_command_in <= 1'b1;
		rd(STATUS_ADDR, 32'h20);
		repeat (3) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk("release", 32'h0, 32'(brake_release_output));
		@(posedge ref_clk_in);
		alarm_in <= 1'b0;
		servo_on_command_in <= 1'b0;
		motor_speed_in <= 16'h0032;
		repeat (6) @(posedge ref_clk_in);
		rd(STATUS_ADDR, 32'h4);
		// software servo-off while stopped passes through the delay state
		motor_stopped_in <= 1'b1;
		wr(CTRL_ADDR, 32'h0);
		wr(CTRL_ADDR, 32'h1);
		wait_rel(1'b1);
		@(posedge ref_clk_in);
		wr(CTRL_ADDR, 32'h0);
		rd(STATUS_ADDR, 32'h12);
		rd(STATUS_ADDR, 32'h4);
		// restart brings registers and routing back to their defaults
		wr(ASSIGN_ADDR, 32'h2);
		rstn_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		@(posedge ref_clk_in);
		rd(ASSIGN_ADDR, 32'h1);
		rd(CTRL_ADDR, 32'h0);
		@(negedge ref_clk_in);
		chk("terminal", 32'h6, 32'(terminal_out));
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
